// file: hw/fp_inexact_exception_logic.sv
// Inexact detection, status update and result write-back after rounding.
// Assumes the rounding datapath presents one rounded operation per op_valid cycle
// and software reaches the status and control register over AXI4-Lite.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module fp_inexact_exception_logic #(
  parameter int ADDR_W = 8,
  parameter int REG_W  = 64
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Rounded operation from the rounding datapath
  input  wire logic               op_valid,
  input  wire logic               op_double,
  input  wire logic               op_sign,
  input  wire logic               op_zero,
  input  wire logic signed [12:0] op_exponent,
  input  wire logic [51:0]        op_fraction,
  input  wire logic               op_bits_lost,
  input  wire logic [4:0]         op_target,
  // Target floating-point register write
  output logic                    fp_register_we,
  output logic [4:0]              fp_register_index,
  output logic [REG_W-1:0]        fp_register_data,
  // Program exception request
  output logic                    program_exception_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [1:0]        rounding_mode_field;
    logic              inexact_enable;
    logic              overflow_enable;
    logic              underflow_enable;
    logic              inexact_sticky_flag;
    logic              enabled_exception_summary;
    logic [4:0]        result_class_field;
    logic              wb_we;
    logic [4:0]        wb_index;
    logic [REG_W-1:0]  wb_data;
    logic              exc_req;
  } state_s;

  state_s state;
  state_s next_state;

  // ----------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------
  logic signed [12:0] emax;
  logic signed [12:0] emin;
  logic signed [12:0] adjust;
  logic               overflow;
  logic               tiny;
  logic               inexact;
  logic               use_max;
  logic [1:0]         kind;
  logic signed [12:0] del_exp;
  logic [51:0]        del_frac;
  logic [63:0]        packed_image;
  logic [4:0]         packed_class;

  assign emax     = op_double ? fp_inexact_pkg::DBL_EMAX : fp_inexact_pkg::SGL_EMAX;
  assign emin     = op_double ? fp_inexact_pkg::DBL_EMIN : fp_inexact_pkg::SGL_EMIN;
  assign adjust   = op_double ? fp_inexact_pkg::DBL_ADJUST : fp_inexact_pkg::SGL_ADJUST;
  assign overflow = !op_zero && (op_exponent > emax);
  assign tiny     = !op_zero && (op_exponent < emin);

  // Largest finite magnitude when rounding toward zero or away from the sign's infinity
  assign use_max = (state.rounding_mode_field == fp_inexact_pkg::RMODE_ZERO)
                || (state.rounding_mode_field == fp_inexact_pkg::RMODE_POS_INF && op_sign)
                || (state.rounding_mode_field == fp_inexact_pkg::RMODE_NEG_INF && !op_sign);

  always_comb begin
    kind     = op_zero ? fp_inexact_pkg::KIND_ZERO : fp_inexact_pkg::KIND_NORMAL;
    del_exp  = op_exponent;
    del_frac = op_fraction;
    inexact  = op_bits_lost;
    if (overflow && state.overflow_enable) begin
      del_exp = op_exponent - adjust;
      inexact = op_bits_lost;
    end else if (overflow) begin
      inexact = 1'b1;
      if (use_max) begin
        kind     = fp_inexact_pkg::KIND_NORMAL;
        del_exp  = emax;
        del_frac = op_double ? fp_inexact_pkg::DBL_FMAX : fp_inexact_pkg::SGL_FMAX;
      end else begin
        kind = fp_inexact_pkg::KIND_INF;
      end
    end else if (tiny && state.underflow_enable) begin
      del_exp = op_exponent + adjust;
      inexact = op_bits_lost;
    end else if (tiny) begin
      kind = (op_fraction == 52'h0) ? fp_inexact_pkg::KIND_ZERO : fp_inexact_pkg::KIND_DENORM;
    end
  end

  fp_result_packer u_packer (
    .sign       (op_sign),
    .single     (!op_double),
    .kind       (kind),
    .exponent   (del_exp),
    .fraction   (del_frac),
    .image      (packed_image),
    .class_code (packed_class)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] reg_image;

  assign wr_fire = state.aw_held && state.w_held && !state.bvalid;
  assign wr_hit  = state.aw_addr == fp_inexact_pkg::STATUS_OFFSET;
  assign rd_hit  = s_axi_araddr == fp_inexact_pkg::STATUS_OFFSET;

  always_comb begin
    reg_image = fp_inexact_pkg::STATUS_RESET;
    reg_image[fp_inexact_pkg::RMODE_LSB +: 2] = state.rounding_mode_field;
    reg_image[fp_inexact_pkg::INX_EN_BIT]     = state.inexact_enable;
    reg_image[fp_inexact_pkg::OE_BIT]         = state.overflow_enable;
    reg_image[fp_inexact_pkg::UFL_EN_BIT]     = state.underflow_enable;
    reg_image[fp_inexact_pkg::STICKY_BIT]     = state.inexact_sticky_flag;
    reg_image[fp_inexact_pkg::SUMMARY_BIT]    = state.enabled_exception_summary;
    reg_image[fp_inexact_pkg::CLASS_LSB +: 5] = state.result_class_field;
  end

  always_comb begin
    next_state = state;
    // Write channels are taken in either order, then answered together
    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = wr_hit ? fp_inexact_pkg::RESP_OKAY : fp_inexact_pkg::RESP_SLVERR;
      if (wr_hit && state.w_strb[0]) begin
        next_state.rounding_mode_field = state.w_data[fp_inexact_pkg::RMODE_LSB +: 2];
        next_state.inexact_enable      = state.w_data[fp_inexact_pkg::INX_EN_BIT];
        next_state.overflow_enable     = state.w_data[fp_inexact_pkg::OE_BIT];
        next_state.underflow_enable    = state.w_data[fp_inexact_pkg::UFL_EN_BIT];
      end
      if (wr_hit && state.w_strb[1]) begin
        next_state.inexact_sticky_flag       = state.w_data[fp_inexact_pkg::STICKY_BIT];
        next_state.enabled_exception_summary = state.w_data[fp_inexact_pkg::SUMMARY_BIT];
      end
    end
    // Reads
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = rd_hit ? reg_image : 32'h0;
      next_state.rresp  = rd_hit ? fp_inexact_pkg::RESP_OKAY : fp_inexact_pkg::RESP_SLVERR;
    end
    // Operation completion; hardware sets win over a same-cycle software clear
    next_state.wb_we   = op_valid;
    next_state.exc_req = 1'b0;
    if (op_valid) begin
      next_state.wb_index           = op_target;
      next_state.wb_data            = REG_W'(packed_image);
      next_state.result_class_field = packed_class;
      if (inexact) begin
        next_state.inexact_sticky_flag = 1'b1;
        if (state.inexact_enable) begin
          next_state.enabled_exception_summary = 1'b1;
          next_state.exc_req                   = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready         = !state.aw_held && !state.bvalid;
  assign s_axi_wready          = !state.w_held && !state.bvalid;
  assign s_axi_bvalid          = state.bvalid;
  assign s_axi_bresp           = state.bresp;
  assign s_axi_arready         = !state.rvalid;
  assign s_axi_rvalid          = state.rvalid;
  assign s_axi_rdata           = state.rdata;
  assign s_axi_rresp           = state.rresp;
  assign fp_register_we        = state.wb_we;
  assign fp_register_index     = state.wb_index;
  assign fp_register_data      = state.wb_data;
  assign program_exception_req = state.exc_req;

endmodule

`default_nettype wire

// file: hw/fp_inexact_pkg.sv
// Constants for the floating-point inexact exception logic.
// Assumes a 32-bit AXI4-Lite register bus and a rounding datapath on the same clock.

package fp_inexact_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATUS_OFFSET = 8'h00;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;

  // Field positions in fp_status_control_reg
  localparam int RMODE_LSB   = 0;
  localparam int INX_EN_BIT  = 3;
  localparam int OE_BIT      = 4;
  localparam int UFL_EN_BIT  = 5;
  localparam int STICKY_BIT  = 8;
  localparam int SUMMARY_BIT = 9;
  localparam int CLASS_LSB   = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Rounding modes
  // ----------------------------------------------------------------
  localparam logic [1:0] RMODE_NEAREST = 2'h0;
  localparam logic [1:0] RMODE_ZERO    = 2'h1;
  localparam logic [1:0] RMODE_POS_INF = 2'h2;
  localparam logic [1:0] RMODE_NEG_INF = 2'h3;

  // ----------------------------------------------------------------
  // Exponent limits and trap adjustments (unbiased, 13-bit signed)
  // ----------------------------------------------------------------
  localparam logic signed [12:0] DBL_ADJUST = 13'sh0600;  // 1536
  localparam logic signed [12:0] SGL_ADJUST = 13'sh00c0;  // 192
  localparam logic signed [12:0] DBL_EMAX   = 13'sh03ff;  // 1023
  localparam logic signed [12:0] DBL_EMIN   = -13'sh03fe; // -1022
  localparam logic signed [12:0] SGL_EMAX   = 13'sh007f;  // 127
  localparam logic signed [12:0] SGL_EMIN   = -13'sh007e; // -126
  localparam logic [12:0]        DBL_BIAS   = 13'h03ff;
  localparam logic [10:0]        EXP_ALL1   = 11'h7ff;
  localparam logic [51:0]        DBL_FMAX   = 52'hf_ffff_ffff_ffff;
  localparam logic [51:0]        SGL_FMAX   = 52'hf_ffff_e000_0000;

  // ----------------------------------------------------------------
  // Delivered result kinds and result class codes
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_NORMAL = 2'h0;
  localparam logic [1:0] KIND_INF    = 2'h1;
  localparam logic [1:0] KIND_ZERO   = 2'h2;
  localparam logic [1:0] KIND_DENORM = 2'h3;

  localparam logic [4:0] CLS_POS_NORMAL = 5'h04;
  localparam logic [4:0] CLS_NEG_NORMAL = 5'h08;
  localparam logic [4:0] CLS_POS_INF    = 5'h05;
  localparam logic [4:0] CLS_NEG_INF    = 5'h09;
  localparam logic [4:0] CLS_POS_ZERO   = 5'h02;
  localparam logic [4:0] CLS_NEG_ZERO   = 5'h12;
  localparam logic [4:0] CLS_POS_DENORM = 5'h14;
  localparam logic [4:0] CLS_NEG_DENORM = 5'h18;

endpackage

// file: hw/fp_result_packer.sv
// Packs a delivered floating-point result into the 64-bit register image and its class code.
// Assumes an unbiased exponent already inside the double range for normal results.
`timescale 1ns/100ps
`default_nettype none

module fp_result_packer (
  // Delivered value
  input  wire logic               sign,
  input  wire logic               single,
  input  wire logic [1:0]         kind,
  input  wire logic signed [12:0] exponent,
  input  wire logic [51:0]        fraction,
  // Packed image
  output logic [63:0]             image,
  output logic [4:0]              class_code
);

  logic [12:0] biased;

  assign biased = exponent + fp_inexact_pkg::DBL_BIAS;

  always_comb begin
    image      = {sign, biased[10:0], fraction};
    class_code = sign ? fp_inexact_pkg::CLS_NEG_NORMAL : fp_inexact_pkg::CLS_POS_NORMAL;
    case (kind)
      fp_inexact_pkg::KIND_INF: begin
        image      = {sign, fp_inexact_pkg::EXP_ALL1, 52'h0};
        class_code = sign ? fp_inexact_pkg::CLS_NEG_INF : fp_inexact_pkg::CLS_POS_INF;
      end
      fp_inexact_pkg::KIND_ZERO: begin
        image      = {sign, 63'h0};
        class_code = sign ? fp_inexact_pkg::CLS_NEG_ZERO : fp_inexact_pkg::CLS_POS_ZERO;
      end
      fp_inexact_pkg::KIND_DENORM: begin
        // Single denormals are ordinary normals in the double image
        if (!single) begin
          image = {sign, 11'h0, fraction};
        end
        class_code = sign ? fp_inexact_pkg::CLS_NEG_DENORM : fp_inexact_pkg::CLS_POS_DENORM;
      end
      default: begin
        image      = {sign, biased[10:0], fraction};
        class_code = sign ? fp_inexact_pkg::CLS_NEG_NORMAL : fp_inexact_pkg::CLS_POS_NORMAL;
      end
    endcase
  end

endmodule

`default_nettype wire

// file: verif/fp_inexact_properties.sv
// Concurrent checks on the ports of the inexact exception logic.
// Assumes it is bound to the top module and that all ports share aclk.
`timescale 1ns/100ps
`default_nettype none

module fp_inexact_properties #(
  parameter int REG_W = 64
) (
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Read channel handshakes
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // Rounded operation
  input wire logic               op_valid,
  input wire logic               op_double,
  input wire logic               op_sign,
  input wire logic               op_zero,
  input wire logic signed [12:0] op_exponent,
  input wire logic               op_bits_lost,
  input wire logic [4:0]         op_target,
  // Results
  input wire logic               fp_register_we,
  input wire logic [4:0]         fp_register_index,
  input wire logic [REG_W-1:0]   fp_register_data,
  input wire logic               program_exception_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_op; op_valid; endsequence
  sequence s_exact_op;
    op_valid && !op_bits_lost && op_exponent <= fp_inexact_pkg::SGL_EMAX;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_we_follows: assert property (s_op |=> fp_register_we
    && fp_register_index == $past(op_target)) else $error("write after operation missing");
  a_we_cause: assert property (fp_register_we |-> $past(op_valid))
    else $error("register write without an operation");
  a_exc_exact: assert property (s_exact_op |=> !program_exception_req)
    else $error("exception on an exact result");
  a_exc_write: assert property (program_exception_req |-> fp_register_we)
    else $error("exception without a result write");
  a_single_image: assert property (s_op ##0 !op_double |=> fp_register_data[28:0] == 29'h0)
    else $error("single result not in double layout");
  a_zero_image: assert property (s_op ##0 op_zero |=> fp_register_data[62:0] == 63'h0
    && fp_register_data[63] == $past(op_sign)) else $error("zero result image wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after accept");
endmodule

`default_nettype wire

// file: verif/fp_round_model.sv
// Rounding datapath model: presents one rounded operation per send call.
// Assumes calls are made just after a rising edge of aclk.
`timescale 1ns/100ps
`default_nettype none

module fp_round_model (
  // Clock
  input  wire logic          aclk,
  // Rounded operation
  output logic               op_valid,
  output logic               op_double,
  output logic               op_sign,
  output logic               op_zero,
  output logic signed [12:0] op_exponent,
  output logic [51:0]        op_fraction,
  output logic               op_bits_lost,
  output logic [4:0]         op_target
);
  initial begin
    {op_valid, op_double, op_sign, op_zero, op_exponent, op_fraction, op_bits_lost, op_target} = '0;
  end

  // Flags are double, sign, zero, bits lost
  task automatic send(input logic [3:0] fl, input logic signed [12:0] e,
                      input logic [11:0] fr, input logic [4:0] t);
    {op_double, op_sign, op_zero, op_bits_lost} <= fl;
    op_valid <= 1'b1;
    op_exponent <= e;
    op_fraction <= {fr, 40'h0};
    op_target <= t;
    @(posedge aclk);
  endtask

  // Fraction and exponent change between operations so stale values are never trusted
  task automatic idle;
    op_valid <= 1'b0;
    op_fraction <= ~op_fraction;
    op_exponent <= ~op_exponent;
    @(posedge aclk);
  endtask
endmodule

`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the inexact exception logic.
// Assumes the rounding model drives the operation port and this bench the register bus.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  typedef struct {
    logic [5:0] c; logic [3:0] f; logic signed [12:0] e; logic [11:0] fr;
    logic [63:0] img; logic [4:0] k; logic [1:0] x;
  } row_s;
  // Control word, flags, exponent, fraction top, image, class, {exception, sticky}
  row_s rows [15] = '{
    '{6'h00, 4'h8, 13'sd0, 12'h000, 64'h3ff0000000000000, 5'h04, 2'h0},
    '{6'h08, 4'hd, 13'sd1, 12'h800, 64'hc008000000000000, 5'h08, 2'h3},
    '{6'h00, 4'h8, 13'sd1024, 12'h000, 64'h7ff0000000000000, 5'h05, 2'h1},
    '{6'h09, 4'hc, 13'sd1024, 12'h000, 64'hffefffffffffffff, 5'h08, 2'h3},
    '{6'h02, 4'hc, 13'sd1024, 12'h000, 64'hffefffffffffffff, 5'h08, 2'h1},
    '{6'h03, 4'h8, 13'sd1024, 12'h000, 64'h7fefffffffffffff, 5'h04, 2'h1},
    '{6'h03, 4'hc, 13'sd1024, 12'h000, 64'hfff0000000000000, 5'h09, 2'h1},
    '{6'h01, 4'h0, 13'sd128, 12'h000, 64'h47efffffe0000000, 5'h04, 2'h1},
    '{6'h10, 4'h8, 13'sd1600, 12'h000, 64'h43f0000000000000, 5'h04, 2'h0},
    '{6'h18, 4'h1, 13'sd200, 12'h000, 64'h4070000000000000, 5'h04, 2'h3},
    '{6'h20, 4'h8, -13'sd1100, 12'h000, 64'h5b30000000000000, 5'h04, 2'h0},
    '{6'h00, 4'h9, -13'sd1023, 12'h800, 64'h0008000000000000, 5'h14, 2'h1},
    '{6'h00, 4'he, 13'sd0, 12'h000, 64'h8000000000000000, 5'h12, 2'h0},
    '{6'h00, 4'h1, 13'sd1, 12'h400, 64'h4004000000000000, 5'h04, 2'h1},
    '{6'h00, 4'h1, -13'sd130, 12'h800, 64'h37d8000000000000, 5'h14, 2'h1}};

  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]        wdata = 32'h0, rdata, q;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic               rready = 1'b0, awready, wready, bvalid, arready, rvalid, we, exc;
  logic [1:0]         bresp, rresp, r;
  logic [4:0]         idx, op_target;
  logic [63:0]        fp_data;
  logic               op_valid, op_double, op_sign, op_zero, op_bits_lost;
  logic signed [12:0] op_exponent;
  logic [51:0]        op_fraction;
  int                 n_tests = 0, n_mismatch = 0, k;
  // Copies taken between edges, so the bench never races the launching edge
  logic               awready_s, wready_s, arready_s, bvalid_s, rvalid_s, we_s, exc_s;
  logic [1:0]         bresp_s, rresp_s;
  logic [31:0]        rdata_s;
  logic [4:0]         idx_s;
  logic [63:0]        data_s;

  always @(negedge aclk) begin
    {awready_s, wready_s, arready_s} <= {awready, wready, arready};
    {bvalid_s, rvalid_s} <= {bvalid, rvalid};
    {we_s, exc_s, idx_s, data_s} <= {we, exc, idx, fp_data};
    {bresp_s, rresp_s, rdata_s} <= {bresp, rresp, rdata};
  end

  fp_inexact_exception_logic fp_inexact_exception_logic_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .op_valid(op_valid), .op_double(op_double), .op_sign(op_sign),
    .op_zero(op_zero), .op_exponent(op_exponent), .op_fraction(op_fraction),
    .op_bits_lost(op_bits_lost), .op_target(op_target), .fp_register_we(we),
    .fp_register_index(idx), .fp_register_data(fp_data), .program_exception_req(exc));

  fp_round_model rnd_i (.aclk(aclk), .op_valid(op_valid), .op_double(op_double),
    .op_sign(op_sign), .op_zero(op_zero), .op_exponent(op_exponent),
    .op_fraction(op_fraction), .op_bits_lost(op_bits_lost), .op_target(op_target));

  always #12.5 aclk = ~aclk;

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One register access; w selects write, waits for the response under a bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] rs, output logic [31:0] rd);
    int i;
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready_s) awvalid <= 1'b0;
      if (wvalid && wready_s) wvalid <= 1'b0;
      if (arvalid && arready_s) arvalid <= 1'b0;
      if ((bready && bvalid_s) || (rready && rvalid_s)) break;
    end
    rs = w ? bresp_s : rresp_s;
    rd = rdata_s;
    {bready, rready} <= 2'b00;
    if (i == 40) begin
      n_mismatch++;
      conclude();
    end
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    chk({57'h0, awready_s, wready_s, arready_s, bvalid_s, rvalid_s, we_s, exc_s}, {57'h0, 7'h70});
    aresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0, r, q);
    chk({30'h0, r, q}, {30'h0, fp_inexact_pkg::RESP_OKAY, fp_inexact_pkg::STATUS_RESET});
    $display("reset values done");
    for (k = 0; k < 15; k++) begin
      bus(1'b1, 8'h00, {26'h0, rows[k].c}, r, q);
      rnd_i.send(rows[k].f, rows[k].e, rows[k].fr, 5'(k));
      rnd_i.idle();
      chk(data_s, rows[k].img);
      chk({57'h0, we_s, idx_s, exc_s}, {57'h0, 1'b1, 5'(k), rows[k].x[1]});
      bus(1'b0, 8'h00, 32'h0, r, q);
      chk({57'h0, q[16:12], q[9:8]}, {57'h0, rows[k].k, rows[k].x});
      $display("row %0d done", k);
    end
    bus(1'b1, 8'h04, 32'hffffffff, r, q);
    chk({62'h0, r}, {62'h0, fp_inexact_pkg::RESP_SLVERR});
    bus(1'b0, 8'h04, 32'h0, r, q);
    chk({30'h0, r, q}, {30'h0, fp_inexact_pkg::RESP_SLVERR, 32'h0});
    $display("unmapped done");
    bus(1'b1, 8'h00, 32'h0, r, q);
    rnd_i.send(4'h9, 13'sd3, 12'h800, 5'd3);
    rnd_i.send(4'h8, 13'sd0, 12'h000, 5'd4);
    rnd_i.idle();
    chk({59'h0, idx_s}, {59'h0, 5'd4});
    bus(1'b0, 8'h00, 32'h0, r, q);
    chk({63'h0, q[8]}, 64'h1);
    $display("back to back done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({57'h0, awready_s, wready_s, arready_s, bvalid_s, rvalid_s, we_s, exc_s}, {57'h0, 7'h70});
    aresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0, r, q);
    chk({32'h0, q}, {32'h0, fp_inexact_pkg::STATUS_RESET});
    $display("second reset done");
    conclude();
  end
endmodule

bind fp_inexact_exception_logic fp_inexact_properties #(.REG_W(REG_W)) chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .op_valid(op_valid), .op_double(op_double), .op_sign(op_sign), .op_zero(op_zero),
  .op_exponent(op_exponent), .op_bits_lost(op_bits_lost), .op_target(op_target),
  .fp_register_we(fp_register_we), .fp_register_index(fp_register_index),
  .fp_register_data(fp_register_data), .program_exception_req(program_exception_req));

`default_nettype wire
